// ===== testbench.sv
// self-checking bench for the vga input status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic vgaDisable = 1'b0;
    logic rdHit;
    logic [7:0] rdData;
    logic [7:0] miscOutput = 8'h00;
    logic [7:0] colourPlaneEnable = 8'h00;
    logic [7:0] paletteColour = 8'h00;
    logic [7:0] expOne;
    vga_status_pkg::io_req_t ioReq = '0;
    vga_status_pkg::video_timing_t pixGenTiming = '0;
    vga_status_pkg::video_timing_t pipeTiming = '0;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    vga_input_status_regs i_dut (.clk(clk), .resetn(resetn), .ioReq(ioReq), .rdData(rdData),
        .rdHit(rdHit), .miscOutput(miscOutput), .colourPlaneEnable(colourPlaneEnable),
        .vgaDisable(vgaDisable), .pixGenTiming(pixGenTiming), .pipeTiming(pipeTiming),
        .paletteColour(paletteColour));
    always #5 clk = ~clk;
    // hang guard: the whole run needs only a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    // compares hit flag and data together so an unknown never matches
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle request, answer checked one edge later
    task access(input logic wr, input logic [15:0] addr, input logic [8:0] exp);
        @(posedge clk);
        #1;
        ioReq = '{rd: ~wr, wr: wr, addr: addr};
        @(posedge clk);
        #1;
        ioReq = '0;
        chk({rdHit, rdData}, exp);
    endtask : access
    task conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk({rdHit, rdData}, 9'h000);
        access(1'b0, 16'h03c2, 9'h110);
        access(1'b1, 16'h03c2, 9'h000);
        access(1'b0, 16'h03c2, 9'h110);
        // walk feedback select, timing source, blanking states and address mode
        for (int i = 0; i < 64; i++) begin
            colourPlaneEnable = {2'b00, i[1:0], 4'h0};
            vgaDisable = i[2];
            pixGenTiming = i[2] ? ~{i[3], i[4]} : {i[3], i[4]};
            pipeTiming = i[2] ? {i[3], i[4]} : ~{i[3], i[4]};
            miscOutput = {7'h00, i[5]};
            paletteColour = 8'(i * 37);
            expOne = {2'b00, paletteColour[4 + i[1:0]], paletteColour[i[1:0]], ~i[4], 2'b00,
                ~(i[3] & i[4])};
            access(1'b0, i[5] ? 16'h03da : 16'h03ba, {1'b1, expOne});
            access(1'b0, i[5] ? 16'h03ba : 16'h03da, 9'h000);
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire

// ===== vga_input_status_regs.sv
// vga input status registers zero and one
`timescale 1ns/1ps
`default_nettype none
`include "vga_status_cfg.svh"
module vga_input_status_regs (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // cpu i/o port
    input wire vga_status_pkg::io_req_t ioReq,
    output logic [7:0] rdData,
    output logic rdHit,
    // configuration from other vga registers
    input wire logic [7:0] miscOutput,
    input wire logic [7:0] colourPlaneEnable,
    input wire logic vgaDisable,
    // timing from the vga pixel generator and from the assigned pipe
    input wire vga_status_pkg::video_timing_t pixGenTiming,
    input wire vga_status_pkg::video_timing_t pipeTiming,
    input wire logic [7:0] paletteColour
);
    logic [7:0] statusOne_next;
    logic [7:0] rdData_next;
    logic rdHit_next;
    logic [1:0] feedback;
    vga_status_pkg::video_timing_t timing;
    logic vRetrace;
    logic hRetrace;
    wire colourMode = miscOutput[`MISC_COLOUR_BIT];
    wire [15:0] oneAddr = colourMode ? `STATUS_ONE_COLOUR_ADDR : `STATUS_ONE_MONO_ADDR; // [RULE5]
    wire hitZero = ioReq.rd && (ioReq.addr == `STATUS_ZERO_ADDR); // [RULE1]
    wire hitOne = ioReq.rd && (ioReq.addr == oneAddr); // [RULE1] [RULE5]

    // timing source: pixel generator, not the sent sync; pipe when vga off
    assign timing = vgaDisable ? pipeTiming : pixGenTiming; // [RULE9] [RULE10]
    // retrace means any non-active span, not just the sync pulse
    assign vRetrace = ~timing.vActive; // [RULE13]
    assign hRetrace = ~timing.hActive; // [RULE12]

    video_feedback_mux feedbackMux (
        .colour(paletteColour),
        .planeSel(colourPlaneEnable[`PLANE_SEL_LSB +: 2]),
        .feedback(feedback)
    );

    // status one: reserved zero, feedback, retrace, blanking; no irq path exists
    assign statusOne_next = {2'b00, feedback, vRetrace, 2'b00,
                             hRetrace | vRetrace}; // [RULE6] [RULE7] [RULE8] [RULE14] [RULE11]

    // read decode; writes never touch anything
    assign rdHit_next = hitZero | hitOne; // [RULE16]
    assign rdData_next = hitZero ? `STATUS_ZERO_VALUE
                       : hitOne ? statusOne_next : 8'h00; // [RULE2] [RULE3] [RULE4]

    // status taken live in the request cycle; only the answer is registered,
    // so a read never sees a value older than one clock
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData <= `STATUS_RESET_VALUE;
            rdHit <= 1'b0;
        end else begin
            rdData <= rdData_next;
            rdHit <= rdHit_next;
        end
    end

    zero_const_a: assert property (@(posedge clk) disable iff (!resetn)
        hitZero |=> rdHit && rdData == 8'h10) else $error("status zero value wrong"); // [RULE2]
    one_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
        hitOne && !hitZero |=> rdData[7:6] == 2'b00 && rdData[2:1] == 2'b00)
        else $error("status one reserved bits set"); // [RULE6]
    vretrace_a: assert property (@(posedge clk) disable iff (!resetn)
        hitOne && !hitZero |=> rdData[3] == $past(vRetrace)) else $error("retrace bit wrong"); // [RULE8]
    blank_a: assert property (@(posedge clk) disable iff (!resetn)
        hitOne && !hitZero |=> rdData[0] == ($past(hRetrace) | $past(vRetrace)))
        else $error("blank bit wrong"); // [RULE14]
    pipe_source_a: assert property (@(posedge clk) disable iff (!resetn)
        vgaDisable |-> vRetrace == ~pipeTiming.vActive) else $error("pipe source wrong"); // [RULE10]
    pixgen_source_a: assert property (@(posedge clk) disable iff (!resetn)
        !vgaDisable |-> vRetrace == ~pixGenTiming.vActive) else $error("pixgen source wrong"); // [RULE9]
    mono_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        ioReq.rd && !colourMode && ioReq.addr == 16'h03da |=> !rdHit) else $error("mono decode"); // [RULE5]
    write_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
        !ioReq.rd |=> !rdHit && rdData == 8'h00) else $error("write produced data"); // [RULE16]
    feedback_a: assert property (@(posedge clk) disable iff (!resetn)
        hitOne && !hitZero |=> rdData[5:4] == $past(feedback)) else $error("feedback wrong"); // [RULE7]
    write_only_a: assert property (@(posedge clk) disable iff (!resetn)
        ioReq.wr && !ioReq.rd |=> !rdHit && rdData == 8'h00) else $error("write answered"); // [RULE16]
    colour_miss_a: assert property (@(posedge clk) disable iff (!resetn)
        ioReq.rd && colourMode && ioReq.addr == 16'h03ba |=> !rdHit) else $error("colour decode"); // [RULE5]
    colour_hit_a: assert property (@(posedge clk) disable iff (!resetn)
        ioReq.rd && colourMode && ioReq.addr == 16'h03da |=> rdHit) else $error("colour hit lost"); // [RULE5]
    reset_idle_a: assert property (@(posedge clk)
        !resetn |=> !rdHit && rdData == 8'h00) else $error("reset answer not idle"); // [RULE16]
    cov_blank_c: cover property (@(posedge clk) hitOne && hRetrace && !vRetrace);
    cov_zero_c: cover property (@(posedge clk) hitZero);
    cov_colour_c: cover property (@(posedge clk) hitOne && colourMode && vRetrace);
    cov_pipe_c: cover property (@(posedge clk) hitOne && vgaDisable);
endmodule : vga_input_status_regs
`default_nettype wire

// ===== vga_status_cfg.svh
// constants for the vga input status register block
// Operation
// [RULE1] direct CPU access, no index step
// [RULE2] status zero bit 7 always zero
// [RULE3] status zero bits 6:5, 3:0 zero
// [RULE4] status zero bit 4 always one
// [RULE5] status one address follows colour/mono mode
// [RULE6] status one bits 7:6 read zero
// [RULE7] bits 5:4 show selected palette colour bits
// [RULE8] bit 3 set during vertical retrace
// [RULE9] retrace taken from pixel generator timing
// [RULE10] VGA disabled: retrace from assigned pipe
// [RULE11] no retrace interrupt from legacy bits
// [RULE12] horizontal retrace is whole non-active line part
// [RULE13] vertical retrace spans non-active lines
// [RULE14] bit 0 set during any blanking
// [RULE15] CPU uses 8/16-bit aligned accesses only
// [RULE16] writes ignored, reads have no side effect
`ifndef VGA_STATUS_CFG_SVH
`define VGA_STATUS_CFG_SVH
`define STATUS_ZERO_ADDR 16'h03c2
`define STATUS_ONE_MONO_ADDR 16'h03ba
`define STATUS_ONE_COLOUR_ADDR 16'h03da
`define STATUS_ZERO_VALUE 8'h10
`define STATUS_RESET_VALUE 8'h00
`define MISC_COLOUR_BIT 0
`define PLANE_SEL_LSB 4
`define VRETRACE_BIT 3
`define BLANK_BIT 0
`endif

// ===== vga_status_pkg.sv
// types shared by the vga input status block
package vga_status_pkg;
    // timing seen by the status logic
    typedef struct packed {
        logic hActive;
        logic vActive;
    } video_timing_t;
    // cpu i/o request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
    } io_req_t;
endpackage : vga_status_pkg

// ===== video_feedback_mux.sv
// selects two of eight palette colour bits for video feedback
`timescale 1ns/1ps
`default_nettype none
module video_feedback_mux (
    // palette path
    input wire logic [7:0] colour,
    input wire logic [1:0] planeSel,
    // selected pair
    output logic [1:0] feedback
);
    // select picks bit pairs 0/4, 1/5, 2/6, 3/7 as on legacy parts
    assign feedback = {colour[{1'b1, planeSel}], colour[{1'b0, planeSel}]}; // [RULE7]
endmodule : video_feedback_mux
`default_nettype wire
